//--- common/psm_cfg.svh
// Register offsets, field positions, reset values and timing for power save
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH
`define PSM_OFS_SAVE_WR 8'h55
`define PSM_OFS_SAVE_RD 8'h56
`define PSM_OFS_CTRL 8'h53
`define PSM_OFS_BRIGHT 8'h51
`define PSM_OFS_STATUS 8'h60
`define PSM_SAVE_RST 8'h00
`define PSM_CTRL_RST 8'h00
`define PSM_BRIGHT_RST 12'h000
`define PSM_BIT_BLOCK 5
`define PSM_BIT_DIM 3
`define PSM_BIT_BACK 2
`define PSM_CTRL_MASK 8'h2C
`define PSM_SAVE_OFF 8'h00
`define PSM_SAVE_LOW 8'h01
`define PSM_SAVE_MED 8'h02
`define PSM_SAVE_HIGH 8'h03
`define PSM_IE_LOW 4'h8
`define PSM_IE_MED 4'h9
`define PSM_IE_HIGH 4'hB
`define PSM_SUN_LOW 4'h4
`define PSM_SUN_MED 4'h5
`define PSM_SUN_HIGH 4'h6
`define PSM_RAMP_STEP_NS 1000
`define PSM_CLK_NS 40
`define PSM_RAMP_CYC ((`PSM_RAMP_STEP_NS + `PSM_CLK_NS - 1) / `PSM_CLK_NS)
`endif

//--- common/psm_pkg.sv
// Types for the power save mode control block
package psm_pkg;
    typedef enum logic [3:0] {
        PSM_CLASS_OFF = 4'h1,
        PSM_CLASS_BRIGHT = 4'h2,
        PSM_CLASS_IMAGE = 4'h4,
        PSM_CLASS_SUN = 4'h8
    } psm_class_t;
endpackage

//--- hdl/psm_top.sv
// Power save selector commands and dimming control behind AHB-Lite
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "psm_cfg.svh"
module psm_top
    import psm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Decoded power save mode
    output logic [3:0] power_class,
    output logic [1:0] power_level,
    output logic power_reserved,
    // Brightness and backlight
    output logic [11:0] display_brightness_value,
    output logic backlight_on
);
    localparam int RAMP_W = 8;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] power_save_selector;
    logic [7:0] ctrl;
    logic [11:0] bright_prog;
    logic [RAMP_W-1:0] ramp_cnt;
    logic ramping;
    logic brightness_block_enable;
    logic display_dimming_enable;
    logic backlight_control_enable;
    logic block_prev;
    logic [11:0] target;
    logic addr_ok;
    logic [7:0] rd_addr;
    logic [31:0] next_rdata;
    logic [7:0] sel_now;
    logic [7:0] ctrl_now;
    logic [11:0] bright_now;
    psm_class_t next_class;
    logic [1:0] next_level;
    logic next_reserved;

    assign brightness_block_enable = ctrl[`PSM_BIT_BLOCK];
    assign display_dimming_enable = ctrl[`PSM_BIT_DIM];
    assign backlight_control_enable = ctrl[`PSM_BIT_BACK];
    assign addr_ok = hsel && hready && htrans[1];
    assign rd_addr = haddr[9:2];

    // Forward a write still in its data phase so a read right behind it
    // returns the new value
    assign sel_now = (wr_pend && wr_addr == `PSM_OFS_SAVE_WR) ?
        hwdata[7:0] : power_save_selector;
    assign ctrl_now = (wr_pend && wr_addr == `PSM_OFS_CTRL) ?
        (hwdata[7:0] & `PSM_CTRL_MASK) : ctrl;
    assign bright_now = (wr_pend && wr_addr == `PSM_OFS_BRIGHT) ?
        hwdata[11:0] : bright_prog;

    // Address phase capture for writes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok)
                wr_addr <= haddr[9:2];
        end
    end

    // Selector store, accepted in every display state
    always_ff @(posedge clock) begin
        if (sys_rst)
            power_save_selector <= `PSM_SAVE_RST;
        else if (wr_pend && wr_addr == `PSM_OFS_SAVE_WR)
            power_save_selector <= hwdata[7:0];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl <= `PSM_CTRL_RST;
            bright_prog <= `PSM_BRIGHT_RST;
        end else if (wr_pend) begin
            if (wr_addr == `PSM_OFS_CTRL)
                ctrl <= hwdata[7:0] & `PSM_CTRL_MASK;
            if (wr_addr == `PSM_OFS_BRIGHT)
                bright_prog <= hwdata[11:0];
        end
    end

    // Read data, registered at the address phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (rd_addr)
            `PSM_OFS_SAVE_RD: next_rdata = {24'h00_0000, sel_now};
            `PSM_OFS_SAVE_WR: next_rdata = {24'h00_0000, sel_now};
            `PSM_OFS_CTRL: next_rdata = {24'h00_0000, ctrl_now};
            `PSM_OFS_BRIGHT: next_rdata = {20'h0_0000, bright_now};
            `PSM_OFS_STATUS: next_rdata = {23'h00_0000, ramping,
                display_brightness_value[7:0]};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
            hrdata <= next_rdata;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Selector decode
    always_comb begin
        next_class = PSM_CLASS_OFF;
        next_level = 2'h0;
        next_reserved = 1'b0;
        if (power_save_selector == `PSM_SAVE_OFF) begin
            next_class = PSM_CLASS_OFF;
        end else if (power_save_selector == `PSM_SAVE_LOW ||
                     power_save_selector == `PSM_SAVE_MED ||
                     power_save_selector == `PSM_SAVE_HIGH) begin
            next_class = PSM_CLASS_BRIGHT;
            next_level = power_save_selector[1:0];
        end else begin
            unique case (power_save_selector[7:4])
                `PSM_IE_LOW: begin
                    next_class = PSM_CLASS_IMAGE;
                    next_level = 2'h1;
                end
                `PSM_IE_MED: begin
                    next_class = PSM_CLASS_IMAGE;
                    next_level = 2'h2;
                end
                `PSM_IE_HIGH: begin
                    next_class = PSM_CLASS_IMAGE;
                    next_level = 2'h3;
                end
                `PSM_SUN_LOW: begin
                    next_class = PSM_CLASS_SUN;
                    next_level = 2'h1;
                end
                `PSM_SUN_MED: begin
                    next_class = PSM_CLASS_SUN;
                    next_level = 2'h2;
                end
                `PSM_SUN_HIGH: begin
                    next_class = PSM_CLASS_SUN;
                    next_level = 2'h3;
                end
                default: next_reserved = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            power_class <= PSM_CLASS_OFF;
            power_level <= 2'h0;
            power_reserved <= 1'b0;
        end else begin
            power_class <= next_class;
            power_level <= next_level;
            power_reserved <= next_reserved;
        end
    end

    // Brightness target and ramp
    assign target = brightness_block_enable ? bright_prog : 12'h000;

    always_ff @(posedge clock) begin
        if (sys_rst)
            block_prev <= 1'b0;
        else
            block_prev <= brightness_block_enable;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ramping <= 1'b0;
            ramp_cnt <= '0;
            display_brightness_value <= `PSM_BRIGHT_RST;
        end else if (!display_dimming_enable) begin
            ramping <= 1'b0;
            display_brightness_value <= target;
        end else if (block_prev != brightness_block_enable) begin
            ramping <= 1'b1;
            ramp_cnt <= RAMP_W'(`PSM_RAMP_CYC - 1);
        end else if (!ramping) begin
            display_brightness_value <= target;
        end else if (ramp_cnt != '0) begin
            ramp_cnt <= ramp_cnt - 1'b1;
        end else if (display_brightness_value == target) begin
            ramping <= 1'b0;
        end else begin
            ramp_cnt <= RAMP_W'(`PSM_RAMP_CYC - 1);
            if (display_brightness_value < target)
                display_brightness_value <=
                    display_brightness_value + 12'h001;
            else
                display_brightness_value <=
                    display_brightness_value - 12'h001;
        end
    end

    // Backlight follows its bit one clock later, ramp or not
    always_ff @(posedge clock) begin
        if (sys_rst)
            backlight_on <= 1'b0;
        else
            backlight_on <= backlight_control_enable;
    end

    selector_store_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_pend && wr_addr == `PSM_OFS_SAVE_WR |=>
        power_save_selector == $past(hwdata[7:0]))
        else $error("selector not stored");
    selector_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        addr_ok && !hwrite && rd_addr == `PSM_OFS_SAVE_RD |=>
        hrdata[7:0] == power_save_selector)
        else $error("selector readback wrong");
    bright_class_a: assert property (@(posedge clock) disable iff (sys_rst)
        power_save_selector == `PSM_SAVE_HIGH |=>
        power_class == PSM_CLASS_BRIGHT && power_level == 2'h3)
        else $error("brightness decode wrong");
    image_class_a: assert property (@(posedge clock) disable iff (sys_rst)
        power_save_selector[7:4] == `PSM_IE_HIGH |=>
        power_class == PSM_CLASS_IMAGE && power_level == 2'h3)
        else $error("image decode wrong");
    sun_class_a: assert property (@(posedge clock) disable iff (sys_rst)
        power_save_selector[7:4] == `PSM_SUN_LOW |=>
        power_class == PSM_CLASS_SUN && power_level == 2'h1)
        else $error("sunlight decode wrong");
    reset_clear_a: assert property (@(posedge clock)
        sys_rst |=> power_save_selector == `PSM_SAVE_RST)
        else $error("selector not cleared");
    block_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
        !brightness_block_enable && !display_dimming_enable |=>
        display_brightness_value == 12'h000)
        else $error("brightness not forced to zero");
    backlight_off_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(backlight_control_enable) |-> ##1 !backlight_on)
        else $error("backlight not off at once");
    ramp_start_a: assert property (@(posedge clock) disable iff (sys_rst)
        display_dimming_enable && $changed(brightness_block_enable) |=>
        ramping ##1 $stable(display_brightness_value))
        else $error("dimming ramp not started");
endmodule // psm_top

//--- verification/psm_host.sv
// Host model that issues power save commands over AHB-Lite
`timescale 1ns/100ps
module psm_host (
    // Clock
    input wire logic clock,
    // AHB-Lite master
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One single word transfer; the address phase drives the inverse of the last data
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hwdata <= ~hwdata;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule // psm_host

//--- verification/testbench.sv
// Self-checking bench for the power save mode control block
`timescale 1ns/100ps
module testbench;
    import psm_pkg::*;
    logic clock;
    logic sys_rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] power_class;
    logic [1:0] power_level;
    logic power_reserved;
    logic [11:0] display_brightness_value;
    logic backlight_on;
    int failures = 0;
    int samples_checked = 0;
    logic [31:0] r;
    // Selector codes and expected {class, level, reserved}
    logic [7:0] sel [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h8A, 8'h9F,
        8'hB3, 8'h45, 8'h5C, 8'h61, 8'h04, 8'h70};
    logic [6:0] dec [12] = '{7'h08, 7'h12, 7'h14, 7'h16, 7'h22, 7'h24,
        7'h26, 7'h42, 7'h44, 7'h46, 7'h01, 7'h01};

    psm_top uut (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .power_class, .power_level, .power_reserved,
        .display_brightness_value, .backlight_on);
    psm_host host (.clock, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata);

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task finish_test;
        $display("Checked %0d, failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        host.xfer(a, 1'b1, d, r);
    endtask

    task rd(input logic [31:0] a);
        host.xfer(a, 1'b0, 32'h0, r);
        check("hresp", {31'h0, hresp}, 32'h0);
        check("hready", {31'h0, hreadyout}, 32'h1);
    endtask

    task test_reset;
        #1;
        check("rst_class", power_class, 4'h1);
        check("rst_bright", display_brightness_value, 12'h000);
        rd(32'h158);
        check("rst_sel", r, 32'h0);
        rd(32'h200);
        check("unmapped", r, 32'h0);
    endtask

    task test_decode;
        for (int i = 0; i < 12; i++) begin
            wr(32'h154, {24'h0, sel[i]});
            wait_cyc(1);
            if (dec[i][0])
                check("reserved", power_reserved, 1'b1);
            else
                check("decode", {power_class, power_level, power_reserved},
                    dec[i]);
            rd(32'h158);
            check("sel_read", r, {24'h0, sel[i]});
            rd(32'h154);
            check("sel_write", r, {24'h0, sel[i]});
        end
    endtask

    task test_bright;
        wr(32'h144, 32'h3);
        wr(32'h14C, 32'h0);
        wait_cyc(2);
        check("blk_off", display_brightness_value, 12'h000);
        wr(32'h14C, 32'h20);
        wait_cyc(2);
        check("blk_on", display_brightness_value, 12'h003);
        wr(32'h14C, 32'h28);
        wr(32'h14C, 32'h08);
        wait_cyc(2);
        check("ramp_dn", display_brightness_value, 12'h003);
        rd(32'h180);
        check("ramping", r[8], 1'b1);
        wait_cyc(120);
        check("dn_end", display_brightness_value, 12'h000);
        wr(32'h14C, 32'h28);
        wait_cyc(2);
        check("ramp_up", display_brightness_value, 12'h000);
        wait_cyc(120);
        check("up_end", display_brightness_value, 12'h003);
    endtask

    task test_back;
        wr(32'h14C, 32'h0C);
        wait_cyc(1);
        check("bl_on", backlight_on, 1'b1);
        wr(32'h14C, 32'h08);
        wait_cyc(1);
        check("bl_off", backlight_on, 1'b0);
    endtask

    task test_midrst;
        wr(32'h154, 32'h61);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        check("mid_class", power_class, 4'h1);
        rd(32'h158);
        check("mid_sel", r, 32'h0);
    endtask

    initial begin
        #2000000;
        failures++;
        finish_test;
    end

    initial begin
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        test_reset;
        test_decode;
        test_bright;
        test_back;
        test_midrst;
        finish_test;
    end
endmodule // testbench
